/* File: hw/uart_status_flags.sv */
/*
  Status flag logic of an asynchronous serial port: first status
  register, data register clear sequences, small oversampling receiver.
  Assumes a 16x baud tick pulse, a transmitter outside that reports
  buffer-to-shifter loads and its shifting activity, synchronous inputs.
*/
// The placing of the registers and strobed register access are this design's own decisions.
// Behaviour
// - status register read-only, writes ignored
// - tx empty set on reset, shifter load
// - tx empty cleared by status read, data write
// - complete set when empty and nothing shifting
// - complete cleared by data, preamble, break request
// - rx full set when character lands
// - rx full cleared by status, data read
// - idle set after 10/11 high bit times
// - idle count may start after start bit
// - idle count may start after stop bit
// - idle cleared by status read, data read
// - idle rearmed only by new character
// - overrun set, new character discarded
// - overrun cleared by status, data read
// - seven/three samples, disagreement sets noise
// - noise cleared by any status, data read
// - framing error on low stop bit
// - framing cleared by status, data read
// - parity error on mismatch when enabled
// - parity cleared by any status, data read
// - long break detect blocks full, framing
// - tx interrupt while empty and enabled
`timescale 1ns/1ps

module uart_status_flags #(
  parameter int OVS = 16
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // receive line
  input  wire logic       rxd_i,
  input  wire logic       baud_tick_i,
  // transmitter side
  input  wire logic       tx_shift_load_i,
  input  wire logic       tx_active_i,
  output logic      [7:0] tx_data_o,
  output logic            tx_data_wr_o,
  output logic            tx_preamble_o,
  output logic            tx_on_o,
  output logic            queue_break_o,
  output logic            nine_bit_o,
  output logic            parity_en_o,
  output logic            parity_odd_o,
  output logic            tx_irq_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (OVS != uart_status_pkg::OVS_RATE) begin : g_bad_ovs
    $error("sample positions serve only 16x oversampling");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                        tx_buffer_empty;
    logic                        tc;
    logic                        rx_buffer_full;
    logic                        idle;
    logic                        ovr;
    logic                        nf;
    logic                        fe;
    logic                        pf;
    logic [7:0]                  snap;
    logic                        snap_seen;
    logic                        tx_pend;
    logic [7:0]                  tx_buf;
    logic                        tx_wr;
    logic                        tx_pre;
    logic                        tx_irq;
    logic                        tx_empty_irq_en;
    logic                        te;
    logic                        queue_break;
    logic                        nine;
    logic                        pe;
    logic                        podd;
    logic                        idle_count_after_stop;
    logic                        long_break_detect_en;
    logic [7:0]                  rdata;
    uart_status_pkg::rx_state_e  rx_st;
    logic [3:0]                  tick;
    logic [3:0]                  bit_idx;
    logic [2:0]                  ones;
    logic [8:0]                  shreg;
    logic                        noise;
    logic                        par;
    logic                        rx_prev;
    logic [3:0]                  idle_bits;
    logic                        idle_arm;
    logic [8:0]                  rx_data;
  } state_s;

  state_s     s_r;
  state_s     s_nxt;
  logic [7:0] status;
  logic       st_rd;
  logic       dat_rd;
  logic       dat_wr;
  logic       ctl_wr;
  logic       cfg_wr;
  logic       te_rise;
  logic       sbk_set;
  logic       tx_req;
  logic       rx_clr;
  logic       tx_buffer_empty_clr;
  logic       tc_clr;
  logic       rx_buffer_full_clr;
  logic       idle_clr;
  logic       ovr_clr;
  logic       fe_clr;
  logic       rx_buffer_full_busy;
  logic       frame_done;
  logic       accept;
  logic       idle_set;
  logic       bit_val;
  logic       bit_nz;
  logic       f_fe;
  logic       f_nf;
  logic       f_pf;
  logic [8:0] f_data;
  logic [3:0] idle_lim;
  logic [3:0] last_bit;
  logic [7:0] rd_word;

  // ----------------------------------------------------------------
  // register decode and clear sequences
  // ----------------------------------------------------------------
  // writes to the status address decode to nothing
  assign st_rd   = rd_i && (addr_i == uart_status_pkg::ADDR_STATUS_ONE);
  assign dat_rd  = rd_i && (addr_i == uart_status_pkg::ADDR_DATA);
  assign dat_wr  = wr_i && (addr_i == uart_status_pkg::ADDR_DATA);
  assign ctl_wr  = wr_i && (addr_i == uart_status_pkg::ADDR_CTRL_TWO);
  assign cfg_wr  = wr_i && (addr_i == uart_status_pkg::ADDR_CONFIG);
  assign te_rise = ctl_wr && wdata_i[uart_status_pkg::CTL_TE] && !s_r.te;
  assign sbk_set = ctl_wr && wdata_i[uart_status_pkg::CTL_SBK];
  assign tx_req  = dat_wr || te_rise || sbk_set;

  // clears other than noise and parity act only on flags seen set by an earlier status read
  assign rx_clr   = dat_rd && s_r.snap_seen;
  assign tx_buffer_empty_clr = dat_wr && s_r.snap_seen && s_r.snap[uart_status_pkg::STS_TX_BUFFER_EMPTY];
  assign tc_clr   = tx_req && s_r.snap_seen && s_r.snap[uart_status_pkg::STS_TC];
  assign rx_buffer_full_clr = rx_clr && s_r.snap[uart_status_pkg::STS_RX_BUFFER_FULL];
  assign idle_clr = rx_clr && s_r.snap[uart_status_pkg::STS_IDLE];
  assign ovr_clr  = rx_clr && s_r.snap[uart_status_pkg::STS_OVR];
  assign fe_clr   = rx_clr && s_r.snap[uart_status_pkg::STS_FE];

  assign status   = {s_r.tx_buffer_empty, s_r.tc, s_r.rx_buffer_full, s_r.idle,
                     s_r.ovr, s_r.nf, s_r.fe, s_r.pf};
  assign idle_lim = s_r.nine ? uart_status_pkg::IDLE_BITS_NINE
                             : uart_status_pkg::IDLE_BITS_EIGHT;
  assign last_bit = s_r.nine ? uart_status_pkg::LAST_BIT_NINE
                             : uart_status_pkg::LAST_BIT_EIGHT;

  // ----------------------------------------------------------------
  // per-bit sample evaluation
  // ----------------------------------------------------------------
  // majority of three samples, noise on any disagreement
  assign bit_val = (s_r.ones >= uart_status_pkg::BIT_SMP_HALF);
  assign bit_nz  = (s_r.ones != 3'h0) && (s_r.ones != uart_status_pkg::BIT_SMP_ALL);

  // frame results at the end of the stop bit
  assign frame_done = baud_tick_i && (s_r.rx_st == uart_status_pkg::RX_STOP)
                      && (s_r.tick == uart_status_pkg::TICK_LAST);
  assign f_fe   = !bit_val;
  assign f_nf   = s_r.noise || bit_nz;
  assign f_pf   = s_r.pe && (s_r.par != s_r.podd);
  assign f_data = s_r.nine ? s_r.shreg : {1'b0, s_r.shreg[8:1]};

  // a character lands only into an empty buffer or one cleared in the same cycle
  assign rx_buffer_full_busy = s_r.rx_buffer_full && !rx_buffer_full_clr;
  assign accept    = frame_done && !s_r.long_break_detect_en && !rx_buffer_full_busy;
  assign idle_set  = s_r.idle_arm && (s_r.idle_bits >= idle_lim);

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 8'h00;
    if (st_rd) begin
      rd_word = status;
    end else if (dat_rd) begin
      rd_word = s_r.rx_data[7:0];
    end else if (rd_i && (addr_i == uart_status_pkg::ADDR_CTRL_TWO)) begin
      rd_word[uart_status_pkg::CTL_TIE] = s_r.tx_empty_irq_en;
      rd_word[uart_status_pkg::CTL_TE]  = s_r.te;
      rd_word[uart_status_pkg::CTL_SBK] = s_r.queue_break;
    end else if (rd_i && (addr_i == uart_status_pkg::ADDR_CONFIG)) begin
      rd_word[uart_status_pkg::CFG_NINE]  = s_r.nine;
      rd_word[uart_status_pkg::CFG_PE]    = s_r.pe;
      rd_word[uart_status_pkg::CFG_PODD]  = s_r.podd;
      rd_word[uart_status_pkg::CFG_ILT]   = s_r.idle_count_after_stop;
      rd_word[uart_status_pkg::CFG_LONG_BREAK_DETECT_EN] = s_r.long_break_detect_en;
      rd_word[uart_status_pkg::CFG_RX8]   = s_r.rx_data[8];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.tx_wr  = dat_wr;
    s_nxt.tx_pre = te_rise;
    s_nxt.rdata  = rd_word;

    // control and config writes
    if (ctl_wr) begin
      s_nxt.tx_empty_irq_en = wdata_i[uart_status_pkg::CTL_TIE];
      s_nxt.te  = wdata_i[uart_status_pkg::CTL_TE];
      s_nxt.queue_break = wdata_i[uart_status_pkg::CTL_SBK];
    end
    if (cfg_wr) begin
      s_nxt.nine  = wdata_i[uart_status_pkg::CFG_NINE];
      s_nxt.pe    = wdata_i[uart_status_pkg::CFG_PE];
      s_nxt.podd  = wdata_i[uart_status_pkg::CFG_PODD];
      s_nxt.idle_count_after_stop   = wdata_i[uart_status_pkg::CFG_ILT];
      s_nxt.long_break_detect_en = wdata_i[uart_status_pkg::CFG_LONG_BREAK_DETECT_EN];
    end
    if (dat_wr) begin
      s_nxt.tx_buf = wdata_i;
    end

    // status read snapshot, consumed by the next data access
    if (st_rd) begin
      s_nxt.snap      = status;
      s_nxt.snap_seen = 1'b1;
    end else if (dat_rd || dat_wr) begin
      s_nxt.snap      = 8'h00;
      s_nxt.snap_seen = 1'b0;
    end

    // transmit flags, set wins over clear for tx empty, clear wins for complete
    s_nxt.tx_buffer_empty = tx_shift_load_i || (s_r.tx_buffer_empty && !tx_buffer_empty_clr);
    if (tx_req) begin
      s_nxt.tx_pend = 1'b1;
    end else if (tx_active_i) begin
      s_nxt.tx_pend = 1'b0;
    end
    s_nxt.tc = (s_r.tx_buffer_empty && !tx_active_i && !s_r.tx_pend && !tx_req)
               || (s_r.tc && !tc_clr);
    s_nxt.tx_irq = s_nxt.tx_empty_irq_en && s_nxt.tx_buffer_empty;

    // receive flags; error bits travel with the character
    s_nxt.rx_buffer_full = accept || rx_buffer_full_busy;
    s_nxt.ovr  = (frame_done && !s_r.long_break_detect_en && rx_buffer_full_busy) || (s_r.ovr && !ovr_clr);
    if (accept) begin
      s_nxt.rx_data = f_data;
      s_nxt.fe      = f_fe;
      s_nxt.nf      = f_nf;
      s_nxt.pf      = f_pf;
    end else begin
      s_nxt.fe = s_r.fe && !fe_clr;
      s_nxt.nf = s_r.nf && !rx_clr;
      s_nxt.pf = s_r.pf && !rx_clr;
    end
    s_nxt.idle = idle_set || (s_r.idle && !idle_clr);
    if (accept) begin
      s_nxt.idle_arm = 1'b1;
    end else if (idle_set) begin
      s_nxt.idle_arm = 1'b0;
    end

    // receiver, one step per oversampling tick
    if (baud_tick_i) begin
      s_nxt.tick    = s_r.tick + 4'h1;
      s_nxt.rx_prev = rxd_i;
      case (s_r.rx_st)
        uart_status_pkg::RX_IDLE: begin
          if (s_r.tick == uart_status_pkg::TICK_LAST) begin
            if (!rxd_i) begin
              s_nxt.idle_bits = 4'h0;
            end else if (s_r.idle_bits != 4'hf) begin
              s_nxt.idle_bits = s_r.idle_bits + 4'h1;
            end
          end
          if (s_r.rx_prev && !rxd_i) begin
            s_nxt.rx_st     = uart_status_pkg::RX_START;
            s_nxt.tick      = 4'h0;
            s_nxt.ones      = 3'h0;
            s_nxt.bit_idx   = 4'h0;
            s_nxt.par       = 1'b0;
            s_nxt.idle_bits = 4'h0;
          end
        end
        uart_status_pkg::RX_START: begin
          // seven samples in the start bit
          if (s_r.tick >= uart_status_pkg::START_SMP_FIRST
              && s_r.tick <= uart_status_pkg::START_SMP_LAST) begin
            s_nxt.ones = s_r.ones + {2'b00, rxd_i};
          end
          if (s_r.tick == uart_status_pkg::TICK_LAST) begin
            s_nxt.ones  = 3'h0;
            s_nxt.noise = (s_r.ones != 3'h0);
            s_nxt.rx_st = (s_r.ones >= uart_status_pkg::START_SMP_HALF)
                          ? uart_status_pkg::RX_IDLE : uart_status_pkg::RX_DATA;
          end
        end
        uart_status_pkg::RX_DATA, uart_status_pkg::RX_STOP: begin
          if (s_r.tick >= uart_status_pkg::BIT_SMP_FIRST
              && s_r.tick <= uart_status_pkg::BIT_SMP_LAST) begin
            s_nxt.ones = s_r.ones + {2'b00, rxd_i};
          end
          if (s_r.tick == uart_status_pkg::TICK_LAST) begin
            s_nxt.ones  = 3'h0;
            s_nxt.noise = s_r.noise || bit_nz;
            // idle counting from the first data bit or after stop
            if (s_r.idle_count_after_stop || !bit_val) begin
              s_nxt.idle_bits = 4'h0;
            end else begin
              s_nxt.idle_bits = s_r.idle_bits + 4'h1;
            end
            if (s_r.rx_st == uart_status_pkg::RX_STOP) begin
              s_nxt.rx_st = uart_status_pkg::RX_IDLE;
            end else begin
              s_nxt.shreg   = {bit_val, s_r.shreg[8:1]};
              s_nxt.par     = s_r.par ^ bit_val;
              s_nxt.bit_idx = s_r.bit_idx + 4'h1;
              if (s_r.bit_idx == last_bit) begin
                s_nxt.rx_st = uart_status_pkg::RX_STOP;
              end
            end
          end
        end
        default: begin
          s_nxt.rx_st = uart_status_pkg::RX_IDLE;
        end
      endcase
    end

    // synchronous reset: only the transmit flags stand set
    if (sys_rst_i) begin
      s_nxt         = '0;
      s_nxt.tx_buffer_empty    = 1'b1;
      s_nxt.tc      = 1'b1;
      s_nxt.rx_prev = 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign rdata_o       = s_r.rdata;
  assign tx_data_o     = s_r.tx_buf;
  assign tx_data_wr_o  = s_r.tx_wr;
  assign tx_preamble_o = s_r.tx_pre;
  assign tx_on_o       = s_r.te;
  assign queue_break_o = s_r.queue_break;
  assign nine_bit_o    = s_r.nine;
  assign parity_en_o   = s_r.pe;
  assign parity_odd_o  = s_r.podd;
  assign tx_irq_o      = s_r.tx_irq;

endmodule // uart_status_flags

/* File: hw/uart_status_pkg.sv */
/*
  Shared constants for the serial status flag block: register map,
  field positions, reset values and receiver sampling figures.
  Assumes a 16x oversampling tick from an external baud generator.
*/
package uart_status_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS_ONE = 4'h0;
  localparam logic [3:0] ADDR_DATA       = 4'h4;
  localparam logic [3:0] ADDR_CTRL_TWO   = 4'h8;
  localparam logic [3:0] ADDR_CONFIG     = 4'hc;

  // ----------------------------------------------------------------
  // serial_status_one field positions
  // ----------------------------------------------------------------
  localparam int STS_TX_BUFFER_EMPTY = 7;
  localparam int STS_TC   = 6;
  localparam int STS_RX_BUFFER_FULL = 5;
  localparam int STS_IDLE = 4;
  localparam int STS_OVR  = 3;
  localparam int STS_NF   = 2;
  localparam int STS_FE   = 1;
  localparam int STS_PF   = 0;
  localparam logic [7:0] RST_STATUS_ONE = 8'hc0;

  // ----------------------------------------------------------------
  // serial_control_two and config field positions
  // ----------------------------------------------------------------
  localparam int CTL_TIE   = 7;
  localparam int CTL_TE    = 3;
  localparam int CTL_SBK   = 0;
  localparam int CFG_NINE  = 0;
  localparam int CFG_PE    = 1;
  localparam int CFG_PODD  = 2;
  localparam int CFG_ILT   = 3;
  localparam int CFG_LONG_BREAK_DETECT_EN = 4;
  localparam int CFG_RX8   = 7;

  // ----------------------------------------------------------------
  // receiver sampling and idle figures
  // ----------------------------------------------------------------
  localparam int         OVS_RATE        = 16;
  localparam logic [3:0] TICK_LAST       = 4'hf;
  localparam logic [3:0] START_SMP_FIRST = 4'h1;
  localparam logic [3:0] START_SMP_LAST  = 4'h7;
  localparam logic [2:0] START_SMP_HALF  = 3'h4;
  localparam logic [3:0] BIT_SMP_FIRST   = 4'h7;
  localparam logic [3:0] BIT_SMP_LAST    = 4'h9;
  localparam logic [2:0] BIT_SMP_ALL     = 3'h3;
  localparam logic [2:0] BIT_SMP_HALF    = 3'h2;
  localparam logic [3:0] LAST_BIT_EIGHT  = 4'h7;
  localparam logic [3:0] LAST_BIT_NINE   = 4'h8;
  localparam logic [3:0] IDLE_BITS_EIGHT = 4'ha;
  localparam logic [3:0] IDLE_BITS_NINE  = 4'hb;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

endpackage

/* File: test/uart_status_chk.sv */
/*
  Port-level checks for the serial status flag block.
  Assumes one clock, mclk_i, and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module uart_status_chk #(
  parameter int OVS = 16
) (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // transmitter side
  input wire logic       tx_shift_load_i,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_data_wr_o,
  input wire logic       tx_preamble_o,
  input wire logic       tx_on_o,
  input wire logic       queue_break_o,
  input wire logic       nine_bit_o,
  input wire logic       parity_en_o,
  input wire logic       parity_odd_o,
  input wire logic       tx_irq_o
);
  // ----------------------------------------------------------------
  // clocking and access sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // status read as first step of every clear
  sequence s_sts_rd;
    rd_i && addr_i == uart_status_pkg::ADDR_STATUS_ONE;
  endsequence
  // status read, data write with empty seen, status read, no load
  sequence s_tx_clear;
    s_sts_rd ##1 (wr_i && addr_i == uart_status_pkg::ADDR_DATA && !tx_shift_load_i
      && rdata_o[uart_status_pkg::STS_TX_BUFFER_EMPTY]) ##1 s_sts_rd ##0 !tx_shift_load_i;
  endsequence
  // status read, break request with complete seen, status read
  sequence s_tc_clear;
    s_sts_rd ##1 (wr_i && addr_i == uart_status_pkg::ADDR_CTRL_TWO
      && wdata_i[uart_status_pkg::CTL_SBK] && rdata_o[uart_status_pkg::STS_TC]) ##1 s_sts_rd;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rdata_quiet: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside read answer");
  a_unmapped_zero: assert property (
    rd_i && addr_i[1:0] != 2'h0 |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_status_wr: assert property (
    wr_i && addr_i == uart_status_pkg::ADDR_STATUS_ONE |=> !tx_data_wr_o && !tx_preamble_o
    && $stable(tx_on_o) && $stable(queue_break_o)) else $error("status write had effect");
  a_data_wr: assert property (
    wr_i && addr_i == uart_status_pkg::ADDR_DATA |=> tx_data_wr_o
    && tx_data_o == $past(wdata_i)) else $error("data write not passed on");
  a_tx_buffer_empty_clear: assert property (
    s_tx_clear |=> !rdata_o[uart_status_pkg::STS_TX_BUFFER_EMPTY]) else $error("tx empty not cleared");
  a_tc_clear: assert property (
    s_tc_clear |=> !rdata_o[uart_status_pkg::STS_TC]) else $error("complete not cleared");
  a_preamble_rise: assert property (
    wr_i && addr_i == uart_status_pkg::ADDR_CTRL_TWO && wdata_i[uart_status_pkg::CTL_TE]
    && !tx_on_o |=> tx_preamble_o && tx_on_o) else $error("preamble not queued");
  a_preamble_cause: assert property (
    tx_preamble_o |-> $past(wr_i) && !$past(tx_on_o) && tx_on_o)
    else $error("preamble without enable rise");
  a_irq_mirror: assert property (
    s_sts_rd ##0 !tx_shift_load_i |=> !tx_irq_o || rdata_o[uart_status_pkg::STS_TX_BUFFER_EMPTY])
    else $error("tx request without empty flag");
  a_cfg_read: assert property (
    rd_i && addr_i == uart_status_pkg::ADDR_CONFIG |=> rdata_o[1] == parity_en_o
    && rdata_o[0] == nine_bit_o && rdata_o[2] == parity_odd_o)
    else $error("config read mismatch");

endmodule // uart_status_chk

bind uart_status_flags uart_status_chk #(.OVS(OVS)) chk_inst (.mclk_i, .sys_rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .tx_shift_load_i, .tx_data_o, .tx_data_wr_o,
  .tx_preamble_o, .tx_on_o, .queue_break_o, .nine_bit_o, .parity_en_o, .parity_odd_o, .tx_irq_o);

/* File: test/uart_line_model.sv */
/*
  Far side of the block: 16x tick source, remote sender on the receive
  line and a transmitter that loads its shifter and shifts for a while.
  Assumes the bench calls send() right after a clock edge.
*/
`timescale 1ns/1ps

module uart_line_model #(
  parameter int LOAD_DLY = 8,
  parameter int BUSY     = 20
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // requests from the block
  input  wire logic tx_data_wr_i,
  input  wire logic tx_req_i,
  // line and transmitter status
  output logic      rxd_o,
  output logic      baud_tick_o,
  output logic      tx_shift_load_o,
  output logic      tx_active_o
);
  logic [7:0] cnt_r;
  logic       ld_r;
  logic       req_q;

  initial rxd_o = 1'b1;

  // tick on every other clock
  always_ff @(posedge mclk_i) baud_tick_o <= ~sys_rst_i & ~baud_tick_o;

  // transmitter: load after a delay, then shift for BUSY cycles
  always_ff @(posedge mclk_i) begin
    req_q <= tx_req_i;
    if (sys_rst_i) begin
      cnt_r <= 8'h00;
      ld_r  <= 1'b0;
    end else if (tx_data_wr_i || (tx_req_i && !req_q)) begin
      cnt_r <= 8'(LOAD_DLY + BUSY);
      ld_r  <= tx_data_wr_i;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign tx_shift_load_o = ld_r && cnt_r == 8'(BUSY);
  assign tx_active_o = cnt_r != 8'h00 && cnt_r <= 8'(BUSY);

  // frame lsb first, 16 ticks a bit, optional one-tick flip in bit 3
  task automatic send(input logic [9:0] fr, input bit glitch);
    for (int b = 0; b < 10; b++) begin
      for (int t = 0; t < 16; t++) begin
        do @(posedge mclk_i); while (!baud_tick_o);
        rxd_o <= (glitch && b == 3 && t == 8) ? ~fr[b] : fr[b];
      end
    end
    do @(posedge mclk_i); while (!baud_tick_o);
    rxd_o <= 1'b1;
  endtask

endmodule // uart_line_model

/* File: test/tb.sv */
/*
  Self-checking bench for the serial status flag block.
  Assumes the package, design, line model and checker compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end

module tb;
  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  localparam logic [3:0] A_STS = uart_status_pkg::ADDR_STATUS_ONE;
  localparam logic [3:0] A_DAT = uart_status_pkg::ADDR_DATA;
  localparam logic [3:0] A_CTL = uart_status_pkg::ADDR_CTRL_TWO;
  localparam logic [3:0] A_CFG = uart_status_pkg::ADDR_CONFIG;
  logic       mclk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, tx_data_o, q;
  logic       rxd_i, baud_tick_i, tx_shift_load_i, tx_active_i, tx_data_wr_o;
  logic       tx_preamble_o, tx_on_o, queue_break_o, nine_bit_o, parity_en_o;
  logic       parity_odd_o, tx_irq_o;
  int         mismatches = 0, checked = 0, cyc = 0;
  logic [7:0] cw [3] = '{8'h5a, 8'h88, 8'h81};
  logic [7:0] edat [5] = '{8'h3c, 8'h5a, 8'h81, 8'h01, 8'h00};
  logic [7:0] ecfg [5] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h10};
  logic [7:0] eexp [5] = '{8'h24, 8'h22, 8'h20, 8'h21, 8'h00};
  logic [4:0] estop = 5'b01101;

  uart_status_flags #(.OVS(16)) uart_status_flags_inst (.mclk_i, .sys_rst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .rxd_i, .baud_tick_i, .tx_shift_load_i, .tx_active_i,
    .tx_data_o, .tx_data_wr_o, .tx_preamble_o, .tx_on_o, .queue_break_o, .nine_bit_o,
    .parity_en_o, .parity_odd_o, .tx_irq_o);
  uart_line_model uart_line_model_inst (.mclk_i, .sys_rst_i, .tx_data_wr_i(tx_data_wr_o),
    .tx_req_i(tx_preamble_o | queue_break_o), .rxd_o(rxd_i), .baud_tick_o(baud_tick_i),
    .tx_shift_load_o(tx_shift_load_i), .tx_active_o(tx_active_i));

  // ----------------------------------------------------------------
  // clock, timeout and bus tasks
  // ----------------------------------------------------------------
  always #2 mclk_i = ~mclk_i;

  // hang guard, about three and a half times the expected run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  // one bus cycle; returns read data seen during it
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] o);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    o = rdata_o;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] o;
    acc(1'b1, 1'b0, a, d, o);
    acc(1'b0, 1'b0, a, 8'h00, o);
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] o;
    acc(1'b0, 1'b1, a, 8'h00, o);
    acc(1'b0, 1'b0, a, 8'h00, o);
    `CHK(o & m, e & m)
  endtask

  // one frame from the remote sender, then let the flags land
  task automatic rx(input logic [7:0] d, input logic sb, input bit g);
    uart_line_model_inst.send({sb, d, 1'b0}, g);
    repeat (40) @(posedge mclk_i);
  endtask

  task automatic results();
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    reg_rd(A_STS, 8'hc0, 8'hff);
    reg_wr(A_STS, 8'h3f);
    reg_rd(A_STS, 8'hc0, 8'hff);
    reg_wr(4'h6, 8'hff);
    reg_rd(4'h6, 8'h00, 8'hff);
    // data write, preamble, break each clear complete after status read
    for (int i = 0; i < 3; i++) begin
      reg_wr(A_CTL, 8'h80);
      repeat (60) @(posedge mclk_i);
      acc(1'b0, 1'b1, A_STS, 8'h00, q);
      acc(1'b1, 1'b0, (i == 0) ? A_DAT : A_CTL, cw[i], q);
      `CHK(q[7:6], 2'b11)
      acc(1'b0, 1'b1, A_STS, 8'h00, q);
      acc(1'b0, 1'b0, A_STS, 8'h00, q);
      `CHK(q[7:6], {i != 0, 1'b0})
      `CHK(tx_irq_o, i != 0)
    end
    reg_wr(A_CTL, 8'h00);
    repeat (60) @(posedge mclk_i);
    // data write with no status read first leaves tx empty set
    reg_rd(A_DAT, 8'h00, 8'h00);
    acc(1'b1, 1'b0, A_DAT, 8'h11, q);
    acc(1'b0, 1'b1, A_STS, 8'h00, q);
    acc(1'b0, 1'b0, A_STS, 8'h00, q);
    `CHK(q[7], 1'b1)
    repeat (60) @(posedge mclk_i);
    // clean character, then idle set once and cleared
    rx(8'ha5, 1'b1, 1'b0);
    reg_rd(A_STS, 8'he0, 8'hff);
    reg_rd(A_DAT, 8'ha5, 8'hff);
    reg_rd(A_STS, 8'hc0, 8'hff);
    repeat (400) @(posedge mclk_i);
    reg_rd(A_STS, 8'hd0, 8'hff);
    reg_rd(A_DAT, 8'ha5, 8'h00);
    repeat (400) @(posedge mclk_i);
    reg_rd(A_STS, 8'hc0, 8'hff);
    // all-ones character: idle early only when counting from start bit
    for (int i = 0; i < 2; i++) begin
      reg_wr(A_CFG, {4'h0, i[0], 3'h0});
      rx(8'hff, 1'b1, 1'b0);
      repeat (56) @(posedge mclk_i);
      reg_rd(A_STS, {3'h1, ~i[0], 4'h0}, 8'h30);
      reg_rd(A_DAT, 8'hff, 8'hff);
      repeat (400) @(posedge mclk_i);
    end
    // noise, framing, parity good and bad, long break detect
    for (int i = 0; i < 5; i++) begin
      reg_wr(A_CFG, ecfg[i]);
      reg_rd(A_CFG, ecfg[i], 8'hff);
      rx(edat[i], estop[i], i == 0);
      reg_rd(A_STS, eexp[i], 8'h2f);
      reg_rd(A_DAT, edat[i], {8{~ecfg[i][4]}});
      reg_rd(A_STS, 8'h00, 8'h2f);
    end
    // second character into a full buffer is dropped
    reg_wr(A_CFG, 8'h00);
    rx(8'h11, 1'b1, 1'b0);
    rx(8'h22, 1'b1, 1'b0);
    reg_rd(A_STS, 8'h28, 8'h2f);
    reg_rd(A_DAT, 8'h11, 8'hff);
    reg_rd(A_STS, 8'h00, 8'h2f);
    results();
  end

endmodule // tb
